// [bus_master.sv]
// Master end: runs write, poll, immediate read and selective read commands.
// Read bytes pass through a FIFO; a full FIFO holds the clock between bytes.
`timescale 1ns/1ns
module bus_master import eeprom_pkg::*; #(
  parameter int QTR = QTR_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // Clock
  input wire logic srst, // Sync reset
  serial_bus_if.master bus, // Two-wire bus
  input wire logic cmd_valid, // Command offered
  output logic cmd_ready, // Idle, takes command
  input wire op_t cmd_op, // Operation
  input wire logic [AW-1:0] cmd_addr, // Byte address
  input wire logic [DW-1:0] cmd_data, // Write data
  input wire logic [7:0] cmd_len, // Bytes to read, at least 1
  output logic done, // Command finished pulse
  output logic acked, // Every byte sent by the master acknowledged
  output logic rd_valid, // Read byte available
  input wire logic rd_ready, // Read byte taken
  output logic [DW-1:0] rd_data // Read byte
);
  localparam int QW = $clog2(QTR);
  typedef enum logic [1:0] {A_START, A_TX, A_RX, A_STOP} act_t;

  logic [QW-1:0] div_r;
  logic tick;
  logic active_r;
  logic eng_r;
  op_t op_r;
  act_t act_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] data_r;
  logic [7:0] left_r;
  logic [2:0] step_r;
  logic nack_r;
  logic [1:0] q_r;
  logic [3:0] b_r;
  logic [DW-1:0] sh_r;
  logic scl_r;
  logic oe_n_r;
  logic done_r;
  logic acked_r;
  logic push_r;
  logic fifo_room;
  act_t act;
  logic [DW-1:0] txb;
  logic more;
  logic ack_slot;
  logic launch;

  assign tick = (div_r == QW'(QTR - 1));
  assign more = (left_r > 8'h1);
  assign ack_slot = (b_r == ACK_SLOT);
  // A push still in flight has not reached the full flag yet, so wait one more cycle
  assign launch = active_r & ~eng_r & ((act != A_RX) | (fifo_room & ~push_r));
  assign bus.scl = scl_r;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_n = oe_n_r;
  assign cmd_ready = ~active_r;
  assign done = done_r;
  assign acked = acked_r;

  // Step table per operation; any nack goes straight to stop
  always_comb begin
    act = A_STOP;
    txb = {DEV_CODE, DONT_CARE, WR_DIR};
    if (!nack_r) begin
      case (op_r)
        OP_WRITE: begin
          case (step_r)
            3'h0: act = A_START;
            3'h1: act = A_TX;
            3'h2: begin act = A_TX; txb = {1'b0, addr_r}; end
            3'h3: begin act = A_TX; txb = data_r; end
            default: act = A_STOP;
          endcase
        end
        // poll is device address byte, then stop
        OP_POLL: begin
          case (step_r)
            3'h0: act = A_START;
            3'h1: act = A_TX;
            default: act = A_STOP;
          endcase
        end
        OP_READ_IMM: begin
          case (step_r)
            3'h0: act = A_START;
            3'h1: begin act = A_TX; txb = {DEV_CODE, DONT_CARE, RD_DIR}; end
            3'h2: act = A_RX;
            default: act = A_STOP;
          endcase
        end
        default: begin
          case (step_r)
            3'h0: act = A_START;
            3'h1: act = A_TX;
            3'h2: begin act = A_TX; txb = {1'b0, addr_r}; end
            3'h3: act = A_START;
            3'h4: begin act = A_TX; txb = {DEV_CODE, DONT_CARE, RD_DIR}; end
            3'h5: act = A_RX;
            default: act = A_STOP;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst | tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      active_r <= 1'b0;
      eng_r <= 1'b0;
      op_r <= OP_WRITE;
      act_r <= A_STOP;
      addr_r <= '0;
      data_r <= '0;
      left_r <= '0;
      step_r <= '0;
      nack_r <= 1'b0;
      q_r <= Q_SET;
      b_r <= '0;
      sh_r <= '0;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
      done_r <= 1'b0;
      acked_r <= 1'b0;
      push_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      push_r <= 1'b0;
      if (cmd_valid & ~active_r) begin
        active_r <= 1'b1;
        op_r <= cmd_op;
        addr_r <= cmd_addr;
        data_r <= cmd_data;
        left_r <= cmd_len;
        step_r <= '0;
        nack_r <= 1'b0;
      end else if (launch) begin
        eng_r <= 1'b1;
        act_r <= act;
        sh_r <= txb;
        b_r <= '0;
        q_r <= Q_SET;
      end else if (eng_r & tick) begin
        q_r <= q_r + 2'h1;
        case (q_r)
          Q_SET: begin
            case (act_r)
              A_START: oe_n_r <= 1'b1;
              A_STOP: oe_n_r <= 1'b0;
              // ack only while more bytes are wanted
              A_RX: oe_n_r <= ack_slot ? ~more : 1'b1;
              default: oe_n_r <= ack_slot | sh_r[DW-1];
            endcase
          end
          Q_HIGH: scl_r <= 1'b1;
          Q_SAMPLE: begin
            if (act_r == A_START) begin
              oe_n_r <= 1'b0;
            end else if (act_r == A_STOP) begin
              oe_n_r <= 1'b1;
            end else if (ack_slot) begin
              nack_r <= (act_r == A_TX) & bus.sda;
            end else begin
              sh_r <= (act_r == A_TX) ? {sh_r[DW-2:0], 1'b0} : {sh_r[DW-2:0], bus.sda};
            end
          end
          default: begin
            scl_r <= (act_r == A_STOP);
            b_r <= b_r + 4'h1;
            if ((act_r == A_START) | (act_r == A_STOP) | ack_slot) begin
              eng_r <= 1'b0;
              push_r <= (act_r == A_RX);
              left_r <= (act_r == A_RX) ? left_r - 8'h1 : left_r;
              if (!((act_r == A_RX) & more)) begin
                step_r <= step_r + 3'h1;
              end
              if (act_r == A_STOP) begin
                active_r <= 1'b0;
                done_r <= 1'b1;
                acked_r <= ~nack_r;
              end
            end
          end
        endcase
      end
    end
  end

  sync_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) rx_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(push_r),
    .in_ready(fifo_room),
    .in_data(sh_r),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule // bus_master

// [eeprom_pkg.sv]
// Shared constants for the serial EEPROM target and its bus master.
// Assumes a single 25 MHz clock shared by both ends.
package eeprom_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  // Self-timed write cycle, microseconds
  localparam int T_WR_US = 5000;
  localparam int WR_CYCLES = T_WR_US * (CLK_HZ / HZ_PER_MHZ);
  // Serial clock rate; a quarter period is the least step, so round up
  localparam int SCL_HZ = 100_000;
  localparam int QTR_CYCLES = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int AW = 7;
  localparam int DW = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam logic RD_DIR = 1'h1;
  localparam logic WR_DIR = 1'h0;
  localparam logic [2:0] DONT_CARE = 3'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] Q_SET = 2'h0;
  localparam logic [1:0] Q_HIGH = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_LOW = 2'h3;
  typedef enum logic [1:0] {OP_WRITE, OP_POLL, OP_READ_IMM, OP_READ_SEL} op_t;
endpackage

// [serial_bus_if.sv]
// Two-wire bus joining the master end and the EEPROM end.
// The shared data line is resolved here from both open-drain enables.
`timescale 1ns/1ns
interface serial_bus_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;
  // Wired-AND: a party pulls low only while its enable is low
  assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport target (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface

// [sync_fifo.sv]
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ns
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Room available
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Consumer takes data
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] cnt_r;
  logic full_r;
  logic empty_r;
  logic push;
  logic pop;
  logic [PW:0] cnt_nxt;
  assign push = in_valid & ~full_r;
  assign pop = out_ready & ~empty_r;
  assign cnt_nxt = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  assign in_ready = ~full_r;
  assign out_valid = ~empty_r;
  assign out_data = mem[rd_ptr_r];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      wr_ptr_r <= push ? PW'((wr_ptr_r + 1'b1) % DEPTH) : wr_ptr_r;
      rd_ptr_r <= pop ? PW'((rd_ptr_r + 1'b1) % DEPTH) : rd_ptr_r;
      cnt_r <= cnt_nxt;
      full_r <= (cnt_nxt == (PW+1)'(DEPTH));
      empty_r <= (cnt_nxt == '0);
    end
  end
endmodule // sync_fifo

// [eeprom_target.sv]
// EEPROM end of the two-wire bus: 128-byte array, polling, protection, reads.
// Assumes bus lines are synchronous to clk and change far slower than it.
`timescale 1ns/1ns
module eeprom_target import eeprom_pkg::*; #(
  parameter int WRITE_CYCLES = WR_CYCLES,
  parameter int ADDR_W = AW
) (
  input wire logic clk, // Clock
  input wire logic srst, // Sync reset
  serial_bus_if.target bus, // Two-wire bus
  input wire logic transmit_only_clock_pin, // High allows writes
  output logic busy, // Write cycle running
  output logic [ADDR_W-1:0] cur_addr // Address counter
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam int DEPTH = 1 << ADDR_W;
  typedef enum logic [2:0] {
    T_IDLE, T_DEVADR, T_ADR_ACK, T_WORDADR, T_DATA, T_WR_ACK, T_SEND, T_MST_ACK
  } tstate_t;

  logic [DW-1:0] mem [DEPTH];
  tstate_t state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [2:0] cnt_r;
  logic got8_r;
  logic [DW-1:0] sh_r;
  logic rw_r;
  logic wrote_r;
  logic [ADDR_W-1:0] addr_r;
  logic busy_r;
  logic [CW-1:0] wc_r;
  logic oe_n_r;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic receiving;
  logic dev_match;
  logic write_ok;
  logic mem_we;
  logic [DW-1:0] rd_byte;
  logic [ADDR_W-1:0] page_next;

  assign scl_rise = bus.scl & ~scl_q_r;
  assign scl_fall = ~bus.scl & scl_q_r;
  assign start_cond = bus.scl & scl_q_r & sda_q_r & ~bus.sda & ~busy_r;
  assign stop_cond = bus.scl & scl_q_r & ~sda_q_r & bus.sda;
  assign receiving = (state_r == T_DEVADR) | (state_r == T_WORDADR) | (state_r == T_DATA);
  assign dev_match = (sh_r[7:4] == DEV_CODE);
  assign write_ok = transmit_only_clock_pin;
  assign mem_we = scl_fall & got8_r & (state_r == T_DATA) & write_ok;
  assign rd_byte = mem[addr_r];
  // Page writes roll within the low four address bits
  assign page_next = {addr_r[ADDR_W-1:4], addr_r[3:0] + 4'h1};
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe_n = oe_n_r;
  assign busy = busy_r;
  assign cur_addr = addr_r;

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[addr_r] <= sh_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= bus.scl;
      sda_q_r <= bus.sda;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      wc_r <= '0;
    end else if (stop_cond & wrote_r & ~busy_r) begin
      busy_r <= 1'b1;
      wc_r <= CW'(WRITE_CYCLES - 1);
    end else if (busy_r) begin
      busy_r <= (wc_r != '0);
      wc_r <= wc_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= T_IDLE;
      cnt_r <= '0;
      got8_r <= 1'b0;
      sh_r <= '0;
      rw_r <= WR_DIR;
      wrote_r <= 1'b0;
      addr_r <= '0;
      oe_n_r <= 1'b1;
    end else if (start_cond) begin
      state_r <= T_DEVADR;
      cnt_r <= '0;
      got8_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (stop_cond) begin
      state_r <= T_IDLE;
      oe_n_r <= 1'b1;
      wrote_r <= 1'b0;
    end else if (scl_rise) begin
      if (receiving) begin
        sh_r <= {sh_r[DW-2:0], bus.sda};
      end
      if (receiving | (state_r == T_SEND)) begin
        cnt_r <= cnt_r + 3'h1;
        got8_r <= (cnt_r == LAST_BIT);
      end
      if (state_r == T_MST_ACK) begin
        state_r <= bus.sda ? T_IDLE : T_ADR_ACK;
      end
    end else if (scl_fall) begin
      got8_r <= 1'b0;
      case (state_r)
        T_DEVADR: begin
          if (got8_r) begin
            state_r <= dev_match ? T_ADR_ACK : T_IDLE;
            oe_n_r <= ~dev_match;
            rw_r <= sh_r[0];
          end
        end
        T_ADR_ACK: begin
          if (rw_r == RD_DIR) begin
            // read from counter, wrap by width
            sh_r <= rd_byte;
            oe_n_r <= rd_byte[DW-1];
            addr_r <= addr_r + 1'b1;
            cnt_r <= '0;
            state_r <= T_SEND;
          end else begin
            oe_n_r <= 1'b1;
            state_r <= T_WORDADR;
          end
        end
        T_WORDADR: begin
          if (got8_r) begin
            addr_r <= sh_r[ADDR_W-1:0];
            oe_n_r <= 1'b0;
            state_r <= T_WR_ACK;
          end
        end
        T_DATA: begin
          if (got8_r) begin
            oe_n_r <= ~write_ok;
            state_r <= T_WR_ACK;
            if (write_ok) begin
              addr_r <= page_next;
              wrote_r <= 1'b1;
            end
          end
        end
        T_WR_ACK: begin
          oe_n_r <= 1'b1;
          state_r <= T_DATA;
        end
        T_SEND: begin
          if (got8_r) begin
            oe_n_r <= 1'b1;
            state_r <= T_MST_ACK;
          end else begin
            sh_r <= {sh_r[DW-2:0], 1'b0};
            oe_n_r <= sh_r[DW-2];
          end
        end
        default: begin
          oe_n_r <= 1'b1;
        end
      endcase
    end
  end
endmodule // eeprom_target

// [eeprom_link_assertions.sv]
// Checker for the two-wire link between the master end and the EEPROM end.
// Assumes one clock with sync reset; sits beside the bus interface instance.
`timescale 1ns/1ns
module eeprom_link_assertions import eeprom_pkg::*; #(
  parameter int WRITE_CYCLES = WR_CYCLES
) (
  input wire logic clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic scl, // Serial clock
  input wire logic sda, // Resolved data line
  input wire logic d_sda_oe_n, // EEPROM pull enable
  input wire logic busy, // Write cycle running
  input wire logic transmit_only_clock_pin // Write allow level
);
  logic scl_r, sda_r, rd_r, nak_r, stored_r, deaf_r;
  logic [3:0] cnt_r;
  logic [1:0] nb_r;
  logic [7:0] sh_r;
  logic [31:0] bcnt_r;
  wire start_c = scl && scl_r && sda_r && !sda;
  wire stop_c = scl && scl_r && !sda_r && sda;
  wire rise_c = scl && !scl_r;
  wire slot_c = rise_c && cnt_r == 4'h8;
  wire addr_slot = slot_c && nb_r == 2'h0;
  wire wr_slot = slot_c && nb_r == 2'h2 && !rd_r;
  wire rd_slot = slot_c && nb_r != 2'h0 && rd_r;
  // Bit and byte tracking; a repeated start wins over the rise just before it
  always_ff @(posedge clk) begin
    scl_r <= srst | scl;
    sda_r <= srst | sda;
    bcnt_r <= (busy && !srst) ? bcnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    if (srst || start_c) begin
      cnt_r <= 4'h0;
      nb_r <= 2'h0;
      nak_r <= 1'h0;
      stored_r <= 1'h0;
      // A start seen while busy is ignored for the whole frame, even if busy ends in it
      deaf_r <= busy;
    end else if (slot_c) begin
      cnt_r <= 4'h0;
      nb_r <= nb_r + {1'h0, nb_r != 2'h2};
      nak_r <= nak_r | sda;
      stored_r <= stored_r | (wr_slot && !sda);
    end else if (rise_c) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rise_c && !slot_c) begin
      sh_r <= {sh_r[6:0], sda};
    end
    if (srst) begin
      rd_r <= 1'h0;
    end else if (addr_slot) begin
      rd_r <= sh_r[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence stored_stop_s;
    stop_c && stored_r;
  endsequence
  sequence busy_on_s;
    ##[1:3] busy;
  endsequence
  addr_ack_a: assert property (addr_slot |-> d_sda_oe_n == !(sh_r[7:4] == DEV_CODE && !deaf_r))
    else $error("address acknowledge wrong");
  busy_quiet_a: assert property (busy |-> d_sda_oe_n)
    else $error("eeprom drives during write cycle");
  protect_ack_a: assert property (wr_slot |-> d_sda_oe_n == !transmit_only_clock_pin)
    else $error("data acknowledge ignores protect level");
  nack_quiet_a: assert property (nak_r |-> d_sda_oe_n)
    else $error("eeprom drives after nack");
  read_slot_a: assert property (rd_slot |-> d_sda_oe_n)
    else $error("eeprom drives master ack slot");
  drive_low_a: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("eeprom changes data while clock high");
  write_start_a: assert property (stored_stop_s |-> busy_on_s)
    else $error("write cycle did not start at stop");
  write_time_a: assert property ($fell(busy) |-> bcnt_r == 32'(WRITE_CYCLES))
    else $error("write cycle length wrong");
endmodule // eeprom_link_assertions

// [eeprom_serial_read_poll_protect_test.sv]
// Testbench joining the master and EEPROM ends over one two-wire bus.
// Assumes package, interface, FIFO and both ends are compiled ahead of it.
`timescale 1ns/1ns
module eeprom_serial_read_poll_protect_test import eeprom_pkg::*;;
  localparam int WCYC = 1000;
  localparam int NB = 10;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic transmit_only_clock_pin = 1'h1;
  logic busy, cmd_ready, done, acked, rd_valid;
  logic [AW-1:0] cur_addr;
  logic cmd_valid = 1'h0;
  op_t cmd_op = OP_POLL;
  logic [AW-1:0] cmd_addr = 7'h00;
  logic [DW-1:0] cmd_data = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic rd_ready = 1'h0;
  logic [DW-1:0] rd_data;
  int fails = 0;
  int n_tests = 0;
  serial_bus_if serial_bus_if_i ();
  eeprom_target #(.WRITE_CYCLES(WCYC)) eeprom_target_i (.clk(clk), .srst(srst),
    .bus(serial_bus_if_i), .transmit_only_clock_pin(transmit_only_clock_pin), .busy(busy),
    .cur_addr(cur_addr));
  bus_master #(.QTR(4), .DEPTH(FIFO_DEPTH)) bus_master_i (.clk(clk), .srst(srst),
    .bus(serial_bus_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len), .done(done), .acked(acked),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  eeprom_link_assertions #(.WRITE_CYCLES(WCYC)) eeprom_link_assertions_i (.clk(clk),
    .srst(srst), .scl(serial_bus_if_i.scl), .sda(serial_bus_if_i.sda),
    .d_sda_oe_n(serial_bus_if_i.d_sda_oe_n), .busy(busy),
    .transmit_only_clock_pin(transmit_only_clock_pin));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk_bit(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Bounded wait, sampled just after each edge so registered flags have landed
  task automatic wait_for(string what, ref logic sig, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge clk);
      #1;
      if (sig === 1'h1) begin
        return;
      end
    end
    fails++;
    $display("CHECK FAILED %s expected 1 seen timeout", what);
    tally_and_finish();
  endtask
  task automatic issue(op_t op, logic [6:0] a, logic [7:0] d, logic [7:0] n);
    wait_for("cmd_ready", cmd_ready, 50);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_len = n;
    cmd_valid = 1'h1;
    @(posedge clk);
    #1 cmd_valid = 1'h0;
  endtask
  task automatic pop(logic [7:0] exp);
    wait_for("rd_valid", rd_valid, 20000);
    chk_byte("read byte", exp, rd_data);
    rd_ready = 1'h1;
    @(posedge clk);
    #1 rd_ready = 1'h0;
  endtask
  task automatic rd1(op_t op, logic [6:0] a, logic [7:0] exp);
    issue(op, a, 8'h00, 8'h01);
    pop(exp);
    wait_for("done", done, 20000);
  endtask
  // Write one byte, then poll until the write cycle is over
  task automatic wr(logic [6:0] a, logic [7:0] d);
    int k;
    issue(OP_WRITE, a, d, 8'h01);
    wait_for("done", done, 20000);
    chk_bit("write acked", 1'h1, acked);
    chk_bit("busy after stop", 1'h1, busy);
    issue(OP_POLL, a, 8'h00, 8'h01);
    wait_for("done", done, 20000);
    chk_bit("early poll acked", 1'h0, acked);
    k = 0;
    while (acked !== 1'h1 && k < 20) begin
      issue(OP_POLL, a, 8'h00, 8'h01);
      wait_for("done", done, 20000);
      k++;
    end
    chk_bit("late poll acked", 1'h1, acked);
    chk_bit("busy after poll", 1'h0, busy);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 1'h0;
    for (int i = 0; i < NB; i++) begin
      wr(7'(7'h7E + i), 8'(8'h30 + i));
    end
    // Protect level low: the write must be refused and start no write cycle
    transmit_only_clock_pin = 1'h0;
    issue(OP_WRITE, 7'h00, 8'hEE, 8'h01);
    wait_for("done", done, 20000);
    chk_bit("protected write acked", 1'h0, acked);
    chk_bit("protected busy", 1'h0, busy);
    rd1(OP_READ_SEL, 7'h00, 8'h32);
    chk_byte("address counter", 8'h01, {1'h0, cur_addr});
    rd1(OP_READ_IMM, 7'h00, 8'h33);
    rd1(OP_READ_SEL, 7'h7F, 8'h31);
    rd1(OP_READ_IMM, 7'h00, 8'h32);
    // Long read with the consumer stalled: FIFO fills and the master must hold
    issue(OP_READ_SEL, 7'h7E, 8'h00, 8'(NB));
    repeat (3000) @(posedge clk);
    #1;
    chk_bit("stalled read valid", 1'h1, rd_valid);
    chk_bit("stalled cmd_ready", 1'h0, cmd_ready);
    for (int i = 0; i < NB; i++) begin
      pop(8'(8'h30 + i));
    end
    wait_for("done", done, 20000);
    chk_byte("counter after wrap", 8'h08, {1'h0, cur_addr});
    tally_and_finish();
  end
endmodule // eeprom_serial_read_poll_protect_test
